// ### rtwd_pkg.sv
// Purpose: Shared constants for the reset timer and watchdog block
// Assumes: 10 MHz aclk; AXI4-Lite register access
// Notes:   Times kept in their own unit, cycle counts derived here
package rtwd_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 10000000;
    localparam int LONG_DELAY_US = 18000;
    localparam int MID_DELAY_NS = 1125000;
    localparam int SHORT_DELAY_NS = 10000;
    localparam int WDOG_PERIOD_US = 18000;
    localparam int LONG_DELAY_CYC = LONG_DELAY_US * (CLK_HZ / 1000000);
    localparam int MID_DELAY_CYC = (MID_DELAY_NS + 99) / 100;
    localparam int SHORT_DELAY_CYC = (SHORT_DELAY_NS + 99) / 100;
    localparam int WDOG_PERIOD_CYC = WDOG_PERIOD_US * (CLK_HZ / 1000000);
    localparam int SYNC_STAGES = 3;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OPTION_OFFSET = 8'h00;
    localparam logic [7:0] CONTROL_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    localparam logic [7:0] OPTION_RESET = 8'hFF;

    // Option fields
    localparam int OPT_WAKE_DIS_BIT = 7;
    localparam int OPT_PULLUP_DIS_BIT = 6;
    localparam int OPT_CLK_SRC_BIT = 5;
    localparam int OPT_EDGE_BIT = 4;
    localparam int OPT_ASSIGN_BIT = 3;
    localparam int OPT_RATIO_MSB = 2;

    // Control register fields (write one pulses)
    localparam int CTL_CLEAR_BIT = 0;
    localparam int CTL_SLEEP_BIT = 1;

    // Status register fields
    localparam int ST_TIMEOUT_N_BIT = 4;
    localparam int ST_CORE_RESET_BIT = 0;
    localparam int ST_SLEEP_BIT = 1;

    // Oscillator modes
    typedef enum logic [2:0] {
        RTWD_OSC_LOW = 3'b000,
        RTWD_OSC_XTAL = 3'b001,
        RTWD_OSC_FAST = 3'b010,
        RTWD_OSC_EXTCLK = 3'b011,
        RTWD_OSC_INT = 3'b100,
        RTWD_OSC_RC = 3'b101
    } rtwd_osc_t;

    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage

// ### rtwd_watchdog.sv
// Purpose: Watchdog counter with optional prescaler
// Assumes: Runs on aclk, which stands in for the free-running RC oscillator
// Notes:   Expiry is a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
module rtwd_watchdog
    import rtwd_pkg::*;
#(
    parameter int PERIOD_CYC = WDOG_PERIOD_CYC
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic enable,
    input wire logic clear,
    input wire logic presc_assign,
    input wire logic [2:0] presc_ratio,
    output logic expire
);
    logic [6:0] presc_count;
    logic [$clog2(PERIOD_CYC+1)-1:0] wd_count;
    logic tick;

    // --------------------------------------------------------
    // Prescaler: divisor 2^ratio when assigned
    // --------------------------------------------------------
    always_comb
    begin
        if (!presc_assign)
            tick = 1'b1;
        else
            tick = (presc_count == ((7'h01 << presc_ratio) - 7'h01));
    end

    // Prescaler count, cleared with the watchdog only when assigned
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !enable)
            presc_count <= 7'h00;
        else if (clear && presc_assign)
            presc_count <= 7'h00;
        else if (tick || !presc_assign)
            presc_count <= 7'h00;
        else
            presc_count <= presc_count + 7'h01;
    end

    // Main count; disabled fuse holds it at zero forever
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !enable)
        begin
            wd_count <= '0;
            expire <= 1'b0;
        end
        else if (clear)
        begin
            wd_count <= '0;
            expire <= 1'b0;
        end
        else if (tick)
        begin
            if (wd_count == $bits(wd_count)'(PERIOD_CYC - 1))
            begin
                wd_count <= '0;
                expire <= 1'b1;
            end
            else
            begin
                wd_count <= wd_count + 1'b1;
                expire <= 1'b0;
            end
        end
        else
            expire <= 1'b0;
    end
endmodule
`default_nettype wire

// ### rtwd_top.sv
// Purpose: Power-on latch, device reset timer and watchdog with registers
// Assumes: aclk stands for the free-running on-chip oscillator; aresetn
//          stands for the power-on detector's output
// Notes:   Registers reached over AXI4-Lite; core reset is active high
//
// Function
// - Power-on reset holds chip, regardless of pin
// - Power-up sets latch, clears timer
// - Timer counts once reset input high; releases
// - Core held in reset while timer active
// - Period depends on oscillator mode, reset type
// - Reset timer runs on every power-up
// - Watchdog timeout in sleep runs full timer
// - All reset sources pass through timer
// - Watchdog on own oscillator, counts in sleep
// - Watchdog expiry resets, wakes from sleep
// - Watchdog reset clears timeout flag bit four
// - Fuse zero disables watchdog permanently
// - Unscaled watchdog expires after 18 ms
// - Option write assigns prescaler to watchdog
// - Clear-watchdog zeroes watchdog and prescaler
// - Sleep zeroes watchdog and prescaler
// - Option layout; resets to all ones
// - Pin-change or comparator wake-up clears watchdog count
// - Pin enable selects external reset or tie
`timescale 1ns/10ps
`default_nettype none
module rtwd_top
    import rtwd_pkg::*;
#(
    parameter int LONG_CYC = LONG_DELAY_CYC,
    parameter int MID_CYC = MID_DELAY_CYC,
    parameter int SHORT_CYC = SHORT_DELAY_CYC,
    parameter int WDOG_CYC = WDOG_PERIOD_CYC
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic external_reset_pin_n,
    input wire logic reset_pin_enable,
    input wire logic watchdog_enable_fuse,
    input wire logic [2:0] osc_mode,
    input wire logic clear_watchdog_instr,
    input wire logic sleep_instr,
    input wire logic pin_change_wake,
    input wire logic comparator_change_wake,
    output logic core_reset,
    output logic timeout_flag_n,
    output logic sleeping,
    output logic [7:0] timer_option_control
);
    localparam int CW = $clog2(LONG_CYC + 1);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [SYNC_STAGES-1:0] pin_sync;
    logic pin_level;
    logic pin_level_q;
    logic power_up;
    logic reset_latch;
    logic [CW-1:0] dly_count;
    logic [CW-1:0] dly_target;
    logic eff_reset_n;
    logic pin_fall;
    logic wdog_expire;
    logic wdog_clear;
    logic wake_event;
    logic ctl_clear;
    logic ctl_sleep;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;

    function automatic logic [CW-1:0] delay_for(input logic [2:0] mode, input logic por);
        begin
            if (mode == RTWD_OSC_LOW || mode == RTWD_OSC_XTAL || mode == RTWD_OSC_FAST)
                delay_for = CW'(LONG_CYC);
            else if (por)
                delay_for = CW'(MID_CYC);
            else
                delay_for = CW'(SHORT_CYC);
        end
    endfunction

    // ------------------------------------------------------------
    // Reset pin synchroniser; tie high when pin function is off
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pin_sync <= '0;
        else
            pin_sync <= {pin_sync[SYNC_STAGES-2:0], external_reset_pin_n};
    end

    // Level changes only when stages two and three agree
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_level <= 1'b0;
            pin_level_q <= 1'b0;
        end
        else
        begin
            if (pin_sync[1] == pin_sync[2])
                pin_level <= pin_sync[2];
            pin_level_q <= pin_level;
        end
    end

    assign eff_reset_n = reset_pin_enable ? pin_level : 1'b1;
    assign pin_fall = reset_pin_enable && pin_level_q && !pin_level;

    // ------------------------------------------------------------
    // Reset latch and device reset timer
    // ------------------------------------------------------------
    assign wdog_clear = ctl_clear || clear_watchdog_instr || ctl_sleep || sleep_instr
                        || wake_event;
    assign wake_event = sleeping && (pin_change_wake || comparator_change_wake);

    // Power-up marker chooses the longer period in INT, EXTCLK and RC modes
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            power_up <= 1'b1;
        else if (reset_latch && dly_count == dly_target)
            power_up <= 1'b0;
    end

    always_comb
    begin
        dly_target = delay_for(osc_mode, power_up);
    end

    // Any source re-arms the latch; hazard: no source is skipped
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            reset_latch <= 1'b1;
            dly_count <= '0;
        end
        else if (pin_fall || wdog_expire || wake_event)
        begin
            reset_latch <= 1'b1;
            dly_count <= '0;
        end
        else if (reset_latch)
        begin
            if (!eff_reset_n)
                dly_count <= '0;
            else if (dly_count == dly_target)
                reset_latch <= 1'b0;
            else
                dly_count <= dly_count + 1'b1;
        end
    end

    // Core held while timer active or pin low
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            core_reset <= 1'b1;
        else
            core_reset <= reset_latch || !eff_reset_n;
    end

    // ------------------------------------------------------------
    // Sleep state and timeout flag
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sleeping <= 1'b0;
        else if (wdog_expire || wake_event || pin_fall)
            sleeping <= 1'b0;
        else if ((ctl_sleep || sleep_instr) && !core_reset)
            sleeping <= 1'b1;
    end

    // Expiry wins over a same-cycle clear or sleep
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            timeout_flag_n <= 1'b1;
        else if (wdog_expire)
            timeout_flag_n <= 1'b0;
        else if (ctl_clear || clear_watchdog_instr || ctl_sleep || sleep_instr)
            timeout_flag_n <= 1'b1;
    end

    // ------------------------------------------------------------
    // Watchdog; clock keeps running while core sleeps
    // ------------------------------------------------------------
    rtwd_watchdog #(
        .PERIOD_CYC(WDOG_CYC)
    ) u_wdog (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(watchdog_enable_fuse),
        .clear(wdog_clear),
        .presc_assign(timer_option_control[OPT_ASSIGN_BIT]),
        .presc_ratio(timer_option_control[OPT_RATIO_MSB:0]),
        .expire(wdog_expire)
    );

    // ------------------------------------------------------------
    // AXI4-Lite write path; address and data taken in either order
    // ------------------------------------------------------------
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end
        else if (do_write)
            aw_held <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        else if (do_write)
            w_held <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= AXI_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr == OPTION_OFFSET || aw_addr == CONTROL_OFFSET)
                           ? AXI_OKAY : AXI_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Option register; every device reset restores all ones
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            timer_option_control <= OPTION_RESET;
        else if (reset_latch)
            timer_option_control <= OPTION_RESET;
        else if (do_write && aw_addr == OPTION_OFFSET && w_strb[0])
            timer_option_control <= w_data[7:0];
    end

    // Control pulses stand for the decoder's instructions
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctl_clear <= 1'b0;
            ctl_sleep <= 1'b0;
        end
        else
        begin
            ctl_clear <= do_write && aw_addr == CONTROL_OFFSET && w_strb[0]
                         && w_data[CTL_CLEAR_BIT];
            ctl_sleep <= do_write && aw_addr == CONTROL_OFFSET && w_strb[0]
                         && w_data[CTL_SLEEP_BIT];
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read path; option is write-only, reads zero
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_axi_arready <= 1'b0;
        else
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= AXI_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= AXI_OKAY;
            if (s_axi_araddr == STATUS_OFFSET)
            begin
                s_axi_rdata[ST_TIMEOUT_N_BIT] <= timeout_flag_n;
                s_axi_rdata[ST_CORE_RESET_BIT] <= core_reset;
                s_axi_rdata[ST_SLEEP_BIT] <= sleeping;
            end
            else if (s_axi_araddr != OPTION_OFFSET && s_axi_araddr != CONTROL_OFFSET)
                s_axi_rresp <= AXI_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule
`default_nettype wire

// ### rtwd_top_sva.sv
// Purpose: Port checks for rtwd_top
// Assumes: One aclk domain, sync active-low aresetn
// Notes:   Bounds suit the shortened counts
`timescale 1ns/10ps
`default_nettype none
module rtwd_top_sva
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic external_reset_pin_n,
    input wire logic reset_pin_enable,
    input wire logic watchdog_enable_fuse,
    input wire logic clear_watchdog_instr,
    input wire logic sleep_instr,
    input wire logic pin_change_wake,
    input wire logic comparator_change_wake,
    input wire logic core_reset,
    input wire logic timeout_flag_n,
    input wire logic sleeping,
    input wire logic [7:0] timer_option_control
);
    // ----
    // Clocking
    // ----
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ----
    // Reset latch and timer
    // ----
    // Reset checks must stay live while reset is low
    AST_RST_CORE: assert property (disable iff (1'b0) !aresetn |=> core_reset)
        else $error("core free in reset");
    AST_RST_OPT: assert property (disable iff (1'b0)
        !aresetn |=> timer_option_control == 8'hFF)
        else $error("option not all ones");
    // Eight cycles covers the pin synchroniser and latch
    AST_PIN_HOLD: assert property ((reset_pin_enable && !external_reset_pin_n)[*8] |-> core_reset)
        else $error("core free with pin low");
    AST_MIN_HOLD: assert property ($rose(core_reset) |=> core_reset[*3])
        else $error("reset shorter than timer");

    // ----
    // Watchdog
    // ----
    AST_FUSE_OFF: assert property ((!watchdog_enable_fuse)[*3] ##0 timeout_flag_n
        |=> timeout_flag_n)
        else $error("watchdog fired with fuse off");
    AST_CLR_FLAG: assert property (clear_watchdog_instr[*2] |=> timeout_flag_n)
        else $error("clear left flag low");
    AST_NO_EARLY: assert property (clear_watchdog_instr ##1 timeout_flag_n
        |-> timeout_flag_n[*8])
        else $error("watchdog expired early");
    AST_WDOG_RST: assert property ($fell(timeout_flag_n) |-> ##[0:3] core_reset)
        else $error("expiry gave no reset");

    // ----
    // Sleep and wake
    // ----
    AST_SLEEP_GO: assert property (sleep_instr && !core_reset && !sleeping && timeout_flag_n
        |=> sleeping)
        else $error("sleep not entered");
    AST_WAKE_RST: assert property (sleeping && (pin_change_wake || comparator_change_wake)
        |-> ##[1:4] (core_reset && !sleeping))
        else $error("wake gave no reset");

    // Main scenarios reached
    cover property (sleeping ##1 !sleeping);
    cover property ($fell(timeout_flag_n));
    cover property ($fell(core_reset));
endmodule

bind rtwd_top rtwd_top_sva rtwd_top_sva_i
(
    .aclk, .aresetn, .external_reset_pin_n, .reset_pin_enable, .watchdog_enable_fuse,
    .clear_watchdog_instr, .sleep_instr, .pin_change_wake, .comparator_change_wake,
    .core_reset, .timeout_flag_n, .sleeping, .timer_option_control
);
`default_nettype wire

// ### rtwd_core_model.sv
// Purpose: Core and instruction decoder facing the reset block
// Assumes: Bench requests instructions by level
// Notes:   Nothing issues while held in reset or asleep
`timescale 1ns/10ps
`default_nettype none
module rtwd_core_model
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic core_reset,
    input wire logic sleeping,
    input wire logic want_clear,
    input wire logic want_sleep,
    output logic clear_watchdog_instr = 1'b0,
    output logic sleep_instr = 1'b0
);
    // A held or halted core fetches nothing
    always @(posedge aclk)
    begin
        clear_watchdog_instr <= aresetn && want_clear && !core_reset && !sleeping;
        sleep_instr <= aresetn && want_sleep && !core_reset && !sleeping;
    end
endmodule
`default_nettype wire

// ### tb_rtwd_top.sv
// Purpose: Self-checking bench for rtwd_top
// Assumes: Shortened counts, core model issues instructions
// Notes:   Each scenario task judges its own results
`timescale 1ns/10ps
`default_nettype none
module tb_rtwd_top
    import rtwd_pkg::*;
;
    localparam int LONG = 40;
    localparam int MID = 20;
    localparam int SHORT = 3;
    localparam int WDOG = 16;
    logic aclk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, external_reset_pin_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, timer_option_control;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic reset_pin_enable = 1'b1, watchdog_enable_fuse = 1'b0, want_clear = 1'b0;
    logic [2:0] osc_mode = RTWD_OSC_LOW;
    logic pin_change_wake = 1'b0, comparator_change_wake = 1'b0, want_sleep = 1'b0;
    logic clear_watchdog_instr, sleep_instr, core_reset, timeout_flag_n, sleeping;
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;

    // ----
    // Design and core model
    // ----
    rtwd_top #(.LONG_CYC(LONG), .MID_CYC(MID), .SHORT_CYC(SHORT), .WDOG_CYC(WDOG)) rtwd_top_i
    (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .external_reset_pin_n, .reset_pin_enable,
        .watchdog_enable_fuse, .osc_mode, .clear_watchdog_instr, .sleep_instr,
        .pin_change_wake, .comparator_change_wake, .core_reset, .timeout_flag_n, .sleeping,
        .timer_option_control
    );
    rtwd_core_model rtwd_core_model_i
    (
        .aclk, .aresetn, .core_reset, .sleeping, .want_clear, .want_sleep,
        .clear_watchdog_instr, .sleep_instr
    );

    // 10 MHz clock
    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    // Hang guard, far above the planned run
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            print_verdict();
        end
    end

    // ----
    // Shared tasks
    // ----
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Edges until a watched output (0 core, 1 flag, 2 sleep) reaches v
    task automatic wait_until(input int s, input logic v, output int n);
        n = 0;
        while ((s == 0 ? core_reset : s == 1 ? timeout_flag_n : sleeping) !== v)
        begin
            @(posedge aclk);
            n++;
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            aw_ok = aw_ok || s_axi_awready;
            w_ok = w_ok || s_axi_wready;
            s_axi_awvalid <= !aw_ok;
            s_axi_wvalid <= !w_ok;
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
        @(posedge aclk);
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, er);
        @(posedge aclk);
    endtask

    // Clear held long enough for two back-to-back instructions
    task automatic kick();
        want_clear <= 1'b1;
        repeat (3) @(posedge aclk);
        want_clear <= 1'b0;
    endtask

    // ----
    // Scenarios
    // ----
    task automatic rst_period(input logic [2:0] m, input logic por, input logic pen,
        input int lo, input int hi);
        int n;
        osc_mode <= m;
        reset_pin_enable <= pen;
        external_reset_pin_n <= 1'b0;
        aresetn <= !por;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (8) @(posedge aclk);
        if (pen)
            chk(core_reset, 1'b1);
        external_reset_pin_n <= 1'b1;
        wait_until(0, 1'b0, n);
        reset_pin_enable <= 1'b1;
        chk(n >= lo && n <= hi, 1'b1);
    endtask

    task automatic reg_test();
        chk(timer_option_control, OPTION_RESET);
        axi_rd(OPTION_OFFSET, 32'h0, AXI_OKAY);
        axi_rd(STATUS_OFFSET, 32'h10, AXI_OKAY);
        axi_rd(8'h0C, 32'h0, AXI_SLVERR);
        axi_wr(8'h0C, 32'h0, AXI_SLVERR);
        chk(timer_option_control, OPTION_RESET);
    endtask

    task automatic fuse_test();
        osc_mode <= RTWD_OSC_INT;
        axi_wr(OPTION_OFFSET, 32'h07, AXI_OKAY);
        repeat (100) @(posedge aclk);
        chk(timeout_flag_n, 1'b1);
        chk(core_reset, 1'b0);
        watchdog_enable_fuse <= 1'b1;
    endtask

    task automatic wdog_period(input logic [7:0] opt, input int p);
        int n;
        axi_wr(OPTION_OFFSET, {24'h0, opt}, AXI_OKAY);
        chk(timer_option_control, opt);
        kick();
        wait_until(1, 1'b0, n);
        chk(n >= p && n <= p + 6, 1'b1);
        wait_until(0, 1'b1, n);
        chk(n <= 3, 1'b1);
        wait_until(0, 1'b0, n);
        axi_rd(STATUS_OFFSET, 32'h0, AXI_OKAY);
    endtask

    task automatic wake_test(input int src);
        int n;
        kick();
        axi_wr(CONTROL_OFFSET, 32'h2, AXI_OKAY);
        wait_until(2, 1'b1, n);
        chk(n <= 2, 1'b1);
        if (src == 0)
            pin_change_wake <= 1'b1;
        else
            comparator_change_wake <= 1'b1;
        @(posedge aclk);
        pin_change_wake <= 1'b0;
        comparator_change_wake <= 1'b0;
        wait_until(0, 1'b1, n);
        chk(n <= 4, 1'b1);
        wait_until(0, 1'b0, n);
        axi_rd(STATUS_OFFSET, 32'h10, AXI_OKAY);
    endtask

    task automatic wdog_wake();
        int n;
        axi_wr(OPTION_OFFSET, 32'h07, AXI_OKAY);
        kick();
        want_sleep <= 1'b1;
        @(posedge aclk);
        want_sleep <= 1'b0;
        wait_until(2, 1'b1, n);
        wait_until(1, 1'b0, n);
        chk(n >= WDOG - 4 && n <= WDOG + 4, 1'b1);
        wait_until(0, 1'b1, n);
        chk(n <= 3, 1'b1);
        wait_until(0, 1'b0, n);
        chk(n >= SHORT, 1'b1);
        axi_rd(STATUS_OFFSET, 32'h0, AXI_OKAY);
    endtask

    task automatic clear_test();
        axi_wr(CONTROL_OFFSET, 32'h1, AXI_OKAY);
        chk(timeout_flag_n, 1'b1);
        axi_wr(OPTION_OFFSET, 32'h07, AXI_OKAY);
        repeat (12)
        begin
            kick();
            repeat (8) @(posedge aclk);
        end
        chk(timeout_flag_n, 1'b1);
        chk(core_reset, 1'b0);
    endtask

    // Main sequence; first call holds reset for 10 cycles
    initial
    begin
        rst_period(RTWD_OSC_LOW, 1'b1, 1'b1, LONG, LONG + 10);
        rst_period(RTWD_OSC_LOW, 1'b0, 1'b1, LONG, LONG + 10);
        rst_period(RTWD_OSC_INT, 1'b1, 1'b1, MID, MID + 10);
        rst_period(RTWD_OSC_INT, 1'b0, 1'b1, SHORT, SHORT + 10);
        rst_period(RTWD_OSC_RC, 1'b1, 1'b0, MID - 8, MID + 2);
        rst_period(RTWD_OSC_EXTCLK, 1'b0, 1'b1, SHORT, SHORT + 10);
        rst_period(RTWD_OSC_XTAL, 1'b0, 1'b1, LONG, LONG + 10);
        rst_period(RTWD_OSC_FAST, 1'b0, 1'b1, LONG, LONG + 10);
        reg_test();
        fuse_test();
        wdog_period(8'h07, WDOG);
        wdog_period(8'h08, WDOG);
        wdog_period(8'h09, 2 * WDOG);
        wdog_period(8'h0A, 4 * WDOG);
        wake_test(0);
        wake_test(1);
        wdog_wake();
        clear_test();
        print_verdict();
    end
endmodule
`default_nettype wire
